// ==== common/pwr_state_regs.svh ====
`ifndef PWR_STATE_REGS_SVH
`define PWR_STATE_REGS_SVH
//
// Contract
// - Exactly four power states: battery monitor, hard power-down, standby, active.
// - Enter battery monitor when enabled, battery below critical and chip enable high.
// - Leave battery monitor only when battery rises above the upper hysteresis threshold; code also leaves when monitor_enable is cleared.
// - Boot ends in active; host may reconfigure the default to standby.
// - Device enters standby on its own when configured; most blocks unpowered.
// - Standby wake sources: own I2C address, RF level detector, loop timer.
// - Any enabled wake event in standby moves the device to active.
// - Active has idle, listener and poller modes; idle keeps RF off.
// - Poller acts as reader and switches transmitter off when RF ends.
// - Polling loop alternates active and standby; each technology has an enable.
// - Loop has a listening phase and a polling phase.
// - Listening stays in standby without field, goes listener when field seen.
// - Low-power polling senses briefly; full polling only when a target answers.
// - Listening phase length is configurable, 500 ms as reference.
// - Host interface is an I2C slave up to 3.4 MBaud.
// - Host interface wakes standby only on its own slave address.
// - Interrupt line with programmable polarity paces host transfers.
// - Power off when battery absent or chip enable off; full power otherwise; code also needs pad_supply and standby or active for full_power.

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_CLK_HZ 40000000
`define LP_OSC_HZ 380000
`define LISTEN_MS_REF 500
// Loop timer counts in the 380 kHz domain
`define LISTEN_TICKS_REF ((`LISTEN_MS_REF * `LP_OSC_HZ) / 1000)
`define SENSE_TICKS 38
`define BOOT_CYCLES 16
`define TECH_COUNT 4
`endif

// ==== common/pwr_state_pkg.sv ====
package pwr_state_pkg;
  typedef enum logic [3:0] {
    ST_MONITOR = 4'h1,
    ST_HPD     = 4'h2,
    ST_STANDBY = 4'h4,
    ST_ACTIVE  = 4'h8
  } pwr_state_t;

  typedef enum logic [2:0] {
    FM_IDLE     = 3'h1,
    FM_LISTENER = 3'h2,
    FM_POLLER   = 3'h4
  } func_mode_t;

  typedef enum logic [1:0] {
    PH_LISTEN = 2'h1,
    PH_POLL   = 2'h2
  } loop_phase_t;
endpackage

// ==== common/loop_if.sv ====
`timescale 1ns/1ps
interface loop_if;
  logic run;
  logic [31:0] listen_ticks;
  logic tick_toggle;
  modport sys (output run, output listen_ticks, input tick_toggle);
  modport timer (input run, input listen_ticks, output tick_toggle);
endinterface

// ==== rtl/loop_timer.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Polling-loop timer on the low-power oscillator
// ----------------------------------------
module loop_timer (
  input wire logic lp_clk,
  input wire logic lp_rst_n,
  loop_if.timer lif
);
  logic run_m_q;
  logic run_s_q;
  logic run_p_q;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic tog_q;
  logic [31:0] len_q;
  // Length is taken once per standby visit, after the run level has settled
  wire start = run_s_q && !run_p_q;
  wire expire = run_p_q && (cnt_q + 32'h1 >= len_q);

  assign cnt_d = (!run_p_q || expire) ? 32'h0 : cnt_q + 32'h1;
  assign lif.tick_toggle = tog_q;

  // Limitation: the length setting must stay still while the device is in standby
  always_ff @(posedge lp_clk) begin
    if (!lp_rst_n) begin
      run_m_q <= 1'b0;
      run_s_q <= 1'b0;
      run_p_q <= 1'b0;
      len_q <= 32'h0;
      cnt_q <= 32'h0;
      tog_q <= 1'b0;
    end else begin
      run_m_q <= lif.run;
      run_s_q <= run_m_q;
      run_p_q <= run_s_q;
      if (start) begin
        len_q <= lif.listen_ticks;
      end
      cnt_q <= cnt_d;
      if (expire) begin
        tog_q <= ~tog_q;
      end
    end
  end
endmodule

// ==== rtl/nfc_power_state_controller.sv ====
`timescale 1ns/1ps
`include "pwr_state_regs.svh"
module nfc_power_state_controller
  import pwr_state_pkg::*;
#(
  parameter int TECHS = `TECH_COUNT,
  parameter int LISTEN_TICKS = `LISTEN_TICKS_REF,
  parameter int SENSE_TICKS = `SENSE_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic lp_clk,
  input wire logic lp_rst_n,
  input wire logic chip_enable_pin,
  input wire logic pad_supply,
  input wire logic battery_supply,
  input wire logic bat_below_entry,
  input wire logic bat_above_exit,
  input wire logic monitor_enable,
  input wire logic auto_standby_enable,
  input wire logic wake_i2c_enable,
  input wire logic wake_rf_enable,
  input wire logic wake_timer_enable,
  input wire logic loop_enable,
  input wire logic [TECHS-1:0] tech_enable,
  input wire logic lp_poll_enable,
  input wire logic [31:0] listen_ticks_cfg,
  input wire logic i2c_addr_match,
  input wire logic rf_field_detect,
  input wire logic target_found,
  input wire logic rf_comm_done,
  input wire logic host_idle_req,
  input wire logic irq_polarity,
  input wire logic data_pending,
  output logic [3:0] power_state,
  output logic [2:0] func_mode,
  output logic [1:0] loop_phase,
  output logic full_power,
  output logic core_supply_on,
  output logic rf_tx_on,
  output logic rf_sense_on,
  output logic host_if_on,
  output logic irq_out,
  output logic [TECHS-1:0] tech_active
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] pin_m_q;
  logic [NSYNC-1:0] pin_s_q;
  wire [NSYNC-1:0] pin_raw = {chip_enable_pin, pad_supply, battery_supply, bat_below_entry,
                              bat_above_exit, i2c_addr_match, rf_field_detect, target_found,
                              rf_comm_done, host_idle_req};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
    end
  end

  wire en_s = pin_s_q[9];
  wire pad_s = pin_s_q[8];
  wire bat_s = pin_s_q[7];
  wire below_s = pin_s_q[6];
  wire above_s = pin_s_q[5];
  wire addr_s = pin_s_q[4];
  wire field_s = pin_s_q[3];
  wire found_s = pin_s_q[2];
  wire done_s = pin_s_q[1];
  wire idle_s = pin_s_q[0];

  // ----------------------------------------
  // Loop timer crossing
  // ----------------------------------------
  loop_if lif ();
  logic tmr_m_q;
  logic tmr_s_q;
  logic tmr_p_q;
  wire timer_evt = tmr_s_q ^ tmr_p_q;

  loop_timer u_timer (
    .lp_clk(lp_clk),
    .lp_rst_n(lp_rst_n),
    .lif(lif.timer)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tmr_m_q <= 1'b0;
      tmr_s_q <= 1'b0;
      tmr_p_q <= 1'b0;
    end else begin
      tmr_m_q <= lif.tick_toggle;
      tmr_s_q <= tmr_m_q;
      tmr_p_q <= tmr_s_q;
    end
  end

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  pwr_state_t st_q;
  pwr_state_t st_d;
  func_mode_t fm_q;
  func_mode_t fm_d;
  loop_phase_t ph_q;
  loop_phase_t ph_d;
  logic [7:0] boot_q;
  logic sensing_q;
  logic sensing_d;
  logic [15:0] sense_q;
  logic irq_q;

  wire powered = bat_s && en_s;
  wire full_pw = powered && pad_s;
  wire mon_enter = monitor_enable && below_s;
  wire wake_i2c = wake_i2c_enable && addr_s;
  wire wake_rf = wake_rf_enable && field_s;
  wire wake_tmr = wake_timer_enable && loop_enable && timer_evt;
  wire any_wake = wake_i2c || wake_rf || wake_tmr;
  wire booted = (boot_q == 8'(`BOOT_CYCLES));
  wire sense_end = (sense_q >= 16'(SENSE_TICKS));
  wire any_tech = |tech_enable;

  always_comb begin
    st_d = st_q;
    fm_d = fm_q;
    ph_d = ph_q;
    sensing_d = sensing_q;
    if (!en_s || !bat_s) begin
      st_d = ST_HPD;
      fm_d = FM_IDLE;
      ph_d = PH_LISTEN;
      sensing_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_HPD: begin
          if (mon_enter) begin
            st_d = ST_MONITOR;
          end else if (booted) begin
            st_d = ST_ACTIVE;
            fm_d = FM_IDLE;
          end
        end
        ST_MONITOR: begin
          if (!monitor_enable || above_s) begin
            st_d = ST_HPD;
          end
        end
        ST_STANDBY: begin
          if (mon_enter) begin
            st_d = ST_MONITOR;
          end else if (any_wake) begin
            st_d = ST_ACTIVE;
            if (wake_rf && loop_enable) begin
              fm_d = FM_LISTENER;
            end else if (wake_tmr && any_tech) begin
              fm_d = FM_POLLER;
              ph_d = PH_POLL;
              sensing_d = lp_poll_enable;
            end else begin
              fm_d = FM_IDLE;
            end
          end
        end
        ST_ACTIVE: begin
          if (mon_enter) begin
            st_d = ST_MONITOR;
            fm_d = FM_IDLE;
          end else begin
            unique case (fm_q)
              FM_IDLE: begin
                if (auto_standby_enable && idle_s) begin
                  st_d = ST_STANDBY;
                  ph_d = PH_LISTEN;
                end
              end
              FM_LISTENER: begin
                if (!field_s) begin
                  fm_d = FM_IDLE;
                end
              end
              FM_POLLER: begin
                if (sensing_q) begin
                  if (found_s) begin
                    sensing_d = 1'b0;
                  end else if (sense_end) begin
                    sensing_d = 1'b0;
                    fm_d = FM_IDLE;
                    ph_d = PH_LISTEN;
                  end
                end else if (done_s) begin
                  fm_d = FM_IDLE;
                  ph_d = PH_LISTEN;
                end
              end
              default: fm_d = FM_IDLE;
            endcase
          end
        end
        default: st_d = ST_HPD;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= ST_HPD;
      fm_q <= FM_IDLE;
      ph_q <= PH_LISTEN;
      sensing_q <= 1'b0;
    end else begin
      st_q <= st_d;
      fm_q <= fm_d;
      ph_q <= ph_d;
      sensing_q <= sensing_d;
    end
  end

  // Boot delay restarts on power-down and waits for enable and battery
  always_ff @(posedge sys_clk) begin
    if (!rst_n || st_q != ST_HPD || !powered) begin
      boot_q <= 8'h00;
    end else if (!booted) begin
      boot_q <= boot_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !sensing_q) begin
      sense_q <= 16'h0000;
    end else if (!sense_end) begin
      sense_q <= sense_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Loop timer control
  // ----------------------------------------
  // configurable listen time
  assign lif.run = loop_enable && (st_q == ST_STANDBY);
  assign lif.listen_ticks = (listen_ticks_cfg == 32'h0) ? 32'(LISTEN_TICKS) : listen_ticks_cfg;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic rf_tx_q;
  logic [TECHS-1:0] tech_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_q <= ~irq_polarity;
      rf_tx_q <= 1'b0;
      tech_q <= '0;
    end else begin
      irq_q <= (data_pending && st_q == ST_ACTIVE) ? irq_polarity : ~irq_polarity;
      rf_tx_q <= (st_d == ST_ACTIVE) && (fm_d == FM_POLLER) && !sensing_d;
      tech_q <= (fm_d == FM_POLLER) ? tech_enable : '0;
    end
  end

  assign power_state = st_q;
  assign func_mode = fm_q;
  assign loop_phase = ph_q;
  assign full_power = full_pw && (st_q == ST_STANDBY || st_q == ST_ACTIVE);
  assign core_supply_on = (st_q == ST_ACTIVE);
  assign rf_tx_on = rf_tx_q;
  assign rf_sense_on = sensing_q;
  assign host_if_on = (st_q == ST_ACTIVE) || (st_q == ST_STANDBY && wake_i2c_enable);
  assign irq_out = irq_q;
  assign tech_active = tech_q;
endmodule

// ==== testbench/nfc_power_state_controller_asserts.sv ====
`timescale 1ns/1ps
module pwr_checker
  import pwr_state_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic chip_enable_pin,
  input wire logic battery_supply,
  input wire logic bat_above_exit,
  input wire logic monitor_enable,
  input wire logic wake_i2c_enable,
  input wire logic i2c_addr_match,
  input wire logic irq_polarity,
  input wire logic data_pending,
  input wire logic [3:0] power_state,
  input wire logic [2:0] func_mode,
  input wire logic full_power,
  input wire logic core_supply_on,
  input wire logic rf_tx_on,
  input wire logic irq_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // State checks
  // ----------------------------------------
  state_onehot_a: assert property ($onehot(power_state))
    else $error("power state not one-hot");
  mode_onehot_a: assert property ($onehot(func_mode))
    else $error("functional mode not one-hot");
  // Three low samples cover the two-flop synchroniser
  pin_low_hpd_a: assert property (!chip_enable_pin [*3] |-> ##[0:2] power_state == ST_HPD)
    else $error("chip enable low without hard power-down");
  no_battery_off_a: assert property (!battery_supply [*3] |-> ##[0:2] !full_power)
    else $error("full power without battery");
  monitor_hold_a: assert property ((power_state == ST_MONITOR && !bat_above_exit &&
    chip_enable_pin && battery_supply && monitor_enable) [*3] |=> power_state == ST_MONITOR)
    else $error("monitor left below exit threshold");
  monitor_off_a: assert property (!monitor_enable && power_state != ST_MONITOR |=>
    power_state != ST_MONITOR) else $error("monitor entered while disabled");
  i2c_wake_a: assert property (power_state == ST_STANDBY && wake_i2c_enable &&
    i2c_addr_match && chip_enable_pin && battery_supply |-> ##[1:4] power_state == ST_ACTIVE)
    else $error("address wake missed");
  standby_core_a: assert property (power_state == ST_STANDBY |-> !core_supply_on && !rf_tx_on)
    else $error("core supplied in standby");
  idle_rf_off_a: assert property (func_mode == FM_IDLE |-> !rf_tx_on)
    else $error("transmitter on in idle");
  irq_idle_a: assert property ((!data_pending && $stable(irq_polarity)) [*2] |->
    irq_out == !irq_polarity) else $error("interrupt active without data");
  wake_c: cover property (power_state == ST_STANDBY ##1 power_state == ST_ACTIVE);
  monitor_c: cover property (power_state == ST_MONITOR);
  poller_c: cover property (func_mode == FM_POLLER && rf_tx_on);
endmodule
bind nfc_power_state_controller pwr_checker chk_u (.*);

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk,
  input wire logic irq_out,
  input wire logic irq_polarity,
  output logic chip_enable_pin,
  output logic i2c_addr_match,
  output logic host_idle_req
);
  initial begin
    chip_enable_pin = 1'b0;
    i2c_addr_match = 1'b0;
    host_idle_req = 1'b0;
  end
  task automatic set_ce(input logic v);
    @(posedge sys_clk) chip_enable_pin <= v;
  endtask
  // Held four edges so the synchronised match is not lost
  task automatic address();
    @(posedge sys_clk) i2c_addr_match <= 1'b1;
    repeat (4) @(posedge sys_clk);
    i2c_addr_match <= 1'b0;
  endtask
  task automatic go_idle(input logic v);
    @(posedge sys_clk) host_idle_req <= v;
  endtask
  task automatic wait_irq(output logic ok);
    ok = 1'b0;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      if (irq_out === irq_polarity) ok = 1'b1;
    end
  endtask
endmodule

// ==== testbench/nfc_power_state_controller_tb_top.sv ====
`timescale 1ns/1ps
module nfc_power_state_controller_tb_top
  import pwr_state_pkg::*;
;
  logic sys_clk = 0, rst_n = 0, lp_clk = 0, lp_rst_n = 0, pad_supply = 1, battery_supply = 1;
  logic bat_below_entry = 0, bat_above_exit = 1, monitor_enable = 0, auto_standby_enable = 0;
  logic wake_i2c_enable = 0, wake_rf_enable = 0, wake_timer_enable = 0, loop_enable = 0;
  logic lp_poll_enable = 0, rf_field_detect = 0, target_found = 0, rf_comm_done = 0;
  logic irq_polarity = 0, data_pending = 0, ok;
  logic [3:0] tech_enable = 4'h0;
  logic [31:0] listen_ticks_cfg = 32'h0;
  logic chip_enable_pin, i2c_addr_match, host_idle_req, full_power, core_supply_on;
  logic rf_tx_on, rf_sense_on, host_if_on, irq_out;
  logic [3:0] power_state, tech_active;
  logic [2:0] func_mode;
  logic [1:0] loop_phase;
  int n_errors = 0, comparisons = 0;
  nfc_power_state_controller #(.LISTEN_TICKS(5)) dut_u (.*);
  host_model host_u (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  // Offset start keeps the two clocks unrelated in phase
  initial begin
    #7;
    forever #62.5 lp_clk = ~lp_clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_ps(input logic [3:0] e, input int lim);
    #1;
    for (int i = 0; i < lim && power_state !== e; i++) cyc(1);
    check("power_state", 32'(e), 32'(power_state));
  endtask
  task automatic boot_standby();
    host_u.set_ce(1'b0);
    cyc(4);
    host_u.set_ce(1'b1);
    wait_ps(ST_ACTIVE, 40);
    host_u.go_idle(1'b1);
    wait_ps(ST_STANDBY, 10);
    host_u.go_idle(1'b0);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    host_u.set_ce(1'b1);
    repeat (7) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge lp_clk);
    lp_rst_n <= 1'b1;
    wait_ps(ST_ACTIVE, 40);
    check("func_mode", 32'(FM_IDLE), 32'(func_mode));
    check("full_power", 32'h1, 32'(full_power));
    $display("test boot done");
    @(posedge sys_clk) auto_standby_enable <= 1'b1;
    boot_standby();
    check("core_supply_on", 32'h0, 32'(core_supply_on));
    host_u.address();
    cyc(6);
    check("power_state", 32'(ST_STANDBY), 32'(power_state));
    @(posedge sys_clk) wake_i2c_enable <= 1'b1;
    host_u.address();
    wait_ps(ST_ACTIVE, 8);
    check("host_if_on", 32'h1, 32'(host_if_on));
    $display("test i2c wake done");
    boot_standby();
    @(posedge sys_clk) {wake_rf_enable, loop_enable, rf_field_detect} <= 3'h7;
    wait_ps(ST_ACTIVE, 8);
    check("func_mode", 32'(FM_LISTENER), 32'(func_mode));
    check("loop_phase", 32'(PH_LISTEN), 32'(loop_phase));
    @(posedge sys_clk) {wake_rf_enable, rf_field_detect} <= 2'h0;
    $display("test rf wake done");
    boot_standby();
    @(posedge sys_clk) {wake_timer_enable, tech_enable} <= 5'h15;
    wait_ps(ST_ACTIVE, 200);
    check("func_mode", 32'(FM_POLLER), 32'(func_mode));
    check("loop_phase", 32'(PH_POLL), 32'(loop_phase));
    check("tech_active", 32'h5, 32'(tech_active));
    check("rf_tx_on", 32'h1, 32'(rf_tx_on));
    @(posedge sys_clk) rf_comm_done <= 1'b1;
    cyc(5);
    check("rf_tx_on", 32'h0, 32'(rf_tx_on));
    @(posedge sys_clk) {rf_comm_done, lp_poll_enable} <= 2'h1;
    $display("test timer wake done");
    boot_standby();
    wait_ps(ST_ACTIVE, 200);
    check("rf_sense_on", 32'h1, 32'(rf_sense_on));
    cyc(41);
    check("func_mode", 32'(FM_IDLE), 32'(func_mode));
    @(posedge sys_clk) listen_ticks_cfg <= 32'h8;
    boot_standby();
    wait_ps(ST_ACTIVE, 200);
    @(posedge sys_clk) target_found <= 1'b1;
    cyc(4);
    check("rf_sense_on", 32'h0, 32'(rf_sense_on));
    check("rf_tx_on", 32'h1, 32'(rf_tx_on));
    check("func_mode", 32'(FM_POLLER), 32'(func_mode));
    @(posedge sys_clk) {target_found, rf_comm_done} <= 2'h1;
    cyc(4);
    check("rf_tx_on", 32'h0, 32'(rf_tx_on));
    @(posedge sys_clk) {lp_poll_enable, wake_timer_enable, rf_comm_done} <= 3'h0;
    $display("test sensing done");
    host_u.set_ce(1'b0);
    wait_ps(ST_HPD, 6);
    host_u.address();
    cyc(4);
    check("power_state", 32'(ST_HPD), 32'(power_state));
    host_u.set_ce(1'b1);
    cyc(10);
    check("power_state", 32'(ST_HPD), 32'(power_state));
    wait_ps(ST_ACTIVE, 40);
    @(posedge sys_clk) battery_supply <= 1'b0;
    cyc(4);
    check("full_power", 32'h0, 32'(full_power));
    @(posedge sys_clk) battery_supply <= 1'b1;
    wait_ps(ST_ACTIVE, 40);
    @(posedge sys_clk) pad_supply <= 1'b0;
    cyc(4);
    check("full_power", 32'h0, 32'(full_power));
    check("power_state", 32'(ST_ACTIVE), 32'(power_state));
    @(posedge sys_clk) pad_supply <= 1'b1;
    cyc(4);
    check("full_power", 32'h1, 32'(full_power));
    $display("test power-down done");
    @(posedge sys_clk) {bat_below_entry, bat_above_exit} <= 2'h2;
    cyc(6);
    check("power_state", 32'(ST_ACTIVE), 32'(power_state));
    @(posedge sys_clk) monitor_enable <= 1'b1;
    wait_ps(ST_MONITOR, 6);
    @(posedge sys_clk) bat_below_entry <= 1'b0;
    cyc(8);
    check("power_state", 32'(ST_MONITOR), 32'(power_state));
    @(posedge sys_clk) {bat_above_exit, monitor_enable} <= 2'h2;
    wait_ps(ST_ACTIVE, 40);
    $display("test monitor done");
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk) {irq_polarity, data_pending} <= {p[0], 1'b1};
      host_u.wait_irq(ok);
      check("irq_seen", 32'h1, 32'(ok));
      @(posedge sys_clk) data_pending <= 1'b0;
      cyc(3);
      check("irq_out", 32'(!p[0]), 32'(irq_out));
    end
    $display("test interrupt done");
    conclude();
  end
  initial begin
    #100us;
    n_errors++;
    conclude();
  end
endmodule
